// ---- core/timer_counter.sv ----
// two mode 0 timer/counters with time base, gating, register port and interrupt
`include "tc_regs.svh"

module timer_counter (
    input wire logic clk,
    input wire logic srst,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_strobe,
    input wire logic rd_strobe,
    output logic [7:0] rdata,
    input wire logic count_pin_zero,
    input wire logic count_pin_one,
    input wire logic [1:0] external_interrupt_pin,
    input wire logic twelve_clk_option,
    output logic irq,
    output logic [1:0] timer_irq_req
);
    import tc_pkg::*;

    localparam logic [3:0] DIV_LAST = 4'(`TC_CLK_PER_CYCLE - 1);
    localparam logic [3:0] HALF_LAST = 4'(`TC_CLK_PER_TURBO - 1);

    tmode_reg_t timer_mode_register;
    logic [1:0] timer_run_bit;
    logic [1:0] timer_overflow_flag;
    logic [1:0] timebase_select_bit;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;

    logic [3:0] div_cnt;
    logic tick12;
    logic tick6;

    logic [1:0] pin_s1;
    logic [1:0] pin_s2;
    logic [1:0] pin_s3;
    logic [1:0] int_s1;
    logic [1:0] int_s2;
    logic opt_s1;
    logic opt_s2;

    mode_cfg_t cfg [2];
    count_t cnt [2];
    logic [1:0] ext_fall;
    logic [1:0] turbo;
    logic [1:0] run_ok;
    logic [1:0] base_tick;
    logic [1:0] count_step;
    logic [1:0] wr_low;
    logic [1:0] wr_high;
    logic [1:0] overflow;

    logic wr_tmode;
    logic wr_tctrl;
    logic wr_ckctrl;
    logic wr_status;
    logic wr_mask;
    logic [1:0] next_flag;
    logic [7:0] next_rdata;

    assign wr_tmode = wr_strobe && addr == `TC_ADDR_TMODE;
    assign wr_tctrl = wr_strobe && addr == `TC_ADDR_TCTRL;
    assign wr_ckctrl = wr_strobe && addr == `TC_ADDR_CKCTRL;
    assign wr_status = wr_strobe && addr == `TC_ADDR_IRQ_STATUS;
    assign wr_mask = wr_strobe && addr == `TC_ADDR_IRQ_MASK;

    // shared time base: one divider feeds both rates so the two timers stay in phase
    always_ff @(posedge clk) begin
        if (srst) begin
            div_cnt <= 4'h0;
            tick12 <= 1'b0;
            tick6 <= 1'b0;
        end else begin
            div_cnt <= (div_cnt == DIV_LAST) ? 4'h0 : div_cnt + 4'h1;
            tick12 <= div_cnt == DIV_LAST;
            tick6 <= div_cnt == DIV_LAST || div_cnt == HALF_LAST;
        end
    end

    // pins: two stages, then a third stage that only the edge detector reads
    always_ff @(posedge clk) begin
        if (srst) begin
            pin_s1 <= `TC_RST_PAIR;
            pin_s2 <= `TC_RST_PAIR;
            pin_s3 <= `TC_RST_PAIR;
            int_s1 <= `TC_RST_PAIR;
            int_s2 <= `TC_RST_PAIR;
            opt_s1 <= 1'b0;
            opt_s2 <= 1'b0;
        end else begin
            pin_s1 <= {count_pin_one, count_pin_zero};
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
            int_s1 <= external_interrupt_pin;
            int_s2 <= int_s1;
            opt_s1 <= twelve_clk_option;
            opt_s2 <= opt_s1;
        end
    end

    assign cfg[0] = timer_mode_register.t0;
    assign cfg[1] = timer_mode_register.t1;

    sequence quiet12;
        !tick12 [*8];
    endsequence

    sequence quiet6;
        !tick6 [*5];
    endsequence

    sequence flag_then_req(int idx);
        timer_overflow_flag[idx] ##1 timer_irq_req[idx];
    endsequence

    generate
        for (genvar i = 0; i < 2; i++) begin : g_timer
            localparam logic [7:0] LOW_ADDR = i ? `TC_ADDR_T1_LOW : `TC_ADDR_T0_LOW;
            localparam logic [7:0] HIGH_ADDR = i ? `TC_ADDR_T1_HIGH : `TC_ADDR_T0_HIGH;

            assign ext_fall[i] = pin_s3[i] & ~pin_s2[i];
            assign turbo[i] = timebase_select_bit[i] & ~opt_s2;
            assign base_tick[i] = cfg[i].ct ? ext_fall[i] : (turbo[i] ? tick6 : tick12);
            assign run_ok[i] = timer_run_bit[i] & (~cfg[i].gate | int_s2[i]);
            // only mode 0 counts here; the other three codes hold the count
            assign count_step[i] = run_ok[i] & base_tick[i]
                & ({cfg[i].mode_field_high, cfg[i].mode_field_low} == `TC_MODE13);
            assign wr_low[i] = wr_strobe && addr == LOW_ADDR;
            assign wr_high[i] = wr_strobe && addr == HIGH_ADDR;

            timer_unit u_unit (
                .clk(clk),
                .srst(srst),
                .count_step(count_step[i]),
                .wr_low(wr_low[i]),
                .wr_high(wr_high[i]),
                .wdata(wdata),
                .cnt(cnt[i]),
                .overflow(overflow[i])
            );

            gate_qualify_a: assert property (
                @(posedge clk) disable iff (srst)
                count_step[i] |-> timer_run_bit[i] && (!cfg[i].gate || int_s2[i])
            ) else $error("timer counted while stopped or gated off");

            pin_source_a: assert property (
                @(posedge clk) disable iff (srst)
                count_step[i] && cfg[i].ct |-> $past(pin_s2[i]) && !pin_s2[i]
            ) else $error("counter mode step without a pin falling edge");

            edge_detect_a: assert property (
                @(posedge clk) disable iff (srst)
                !$past(srst) && $past(pin_s2[i]) && !pin_s2[i] |-> ext_fall[i]
            ) else $error("falling edge on count pin missed");

            req_follow_a: assert property (
                @(posedge clk) disable iff (srst)
                overflow[i] && irq_mask[i] && !wr_strobe |=> flag_then_req(i)
            ) else $error("overflow did not raise the timer request");
        end
    endgenerate

    // configuration written by software
    always_ff @(posedge clk) begin
        if (srst) begin
            timer_mode_register <= tmode_reg_t'(`TC_RST_BYTE);
        end else if (wr_tmode) begin
            timer_mode_register <= tmode_reg_t'(wdata);
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            timer_run_bit <= `TC_RST_PAIR;
        end else if (wr_tctrl) begin
            timer_run_bit <= {wdata[`TC_TCTRL_RUN1], wdata[`TC_TCTRL_RUN0]};
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            timebase_select_bit <= `TC_RST_PAIR;
        end else if (wr_ckctrl) begin
            timebase_select_bit <= {wdata[`TC_CK_TB1], wdata[`TC_CK_TB0]};
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            irq_mask <= `TC_RST_PAIR;
        end else if (wr_mask) begin
            irq_mask <= wdata[1:0];
        end
    end

    // overflow flags: software may write them, but a new overflow beats the write
    assign next_flag = wr_tctrl
        ? {wdata[`TC_TCTRL_FLAG1], wdata[`TC_TCTRL_FLAG0]}
        : timer_overflow_flag;

    always_ff @(posedge clk) begin
        if (srst) begin
            timer_overflow_flag <= `TC_RST_PAIR;
        end else begin
            timer_overflow_flag <= overflow | next_flag;
        end
    end

    // sticky status, write one to clear, set wins
    always_ff @(posedge clk) begin
        if (srst) begin
            irq_status <= `TC_RST_PAIR;
        end else begin
            irq_status <= overflow | (irq_status & ~(wr_status ? wdata[1:0] : 2'h0));
        end
    end

    // requests lag the flags by one cycle so that every output is a flop
    always_ff @(posedge clk) begin
        if (srst) begin
            timer_irq_req <= `TC_RST_PAIR;
            irq <= 1'b0;
        end else begin
            timer_irq_req <= timer_overflow_flag & irq_mask;
            irq <= |(irq_status & irq_mask);
        end
    end

    always_comb begin
        next_rdata = `TC_RST_BYTE;
        case (addr)
            `TC_ADDR_T0_LOW: next_rdata = cnt[0].low;
            `TC_ADDR_T0_HIGH: next_rdata = cnt[0].high;
            `TC_ADDR_T1_LOW: next_rdata = cnt[1].low;
            `TC_ADDR_T1_HIGH: next_rdata = cnt[1].high;
            `TC_ADDR_TMODE: next_rdata = timer_mode_register;
            `TC_ADDR_TCTRL: begin
                next_rdata[`TC_TCTRL_RUN0] = timer_run_bit[0];
                next_rdata[`TC_TCTRL_FLAG0] = timer_overflow_flag[0];
                next_rdata[`TC_TCTRL_RUN1] = timer_run_bit[1];
                next_rdata[`TC_TCTRL_FLAG1] = timer_overflow_flag[1];
            end
            `TC_ADDR_CKCTRL: begin
                next_rdata[`TC_CK_TB0] = timebase_select_bit[0];
                next_rdata[`TC_CK_TB1] = timebase_select_bit[1];
            end
            `TC_ADDR_IRQ_STATUS: next_rdata[1:0] = irq_status;
            `TC_ADDR_IRQ_MASK: next_rdata[1:0] = irq_mask;
            default: next_rdata = `TC_RST_BYTE;
        endcase
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge clk) begin
        if (srst) begin
            rdata <= `TC_RST_BYTE;
        end else begin
            rdata <= rd_strobe ? next_rdata : `TC_RST_BYTE;
        end
    end

    base_twelve_a: assert property (
        @(posedge clk) disable iff (srst)
        tick12 |=> quiet12 ##4 tick12
    ) else $error("standard time base is not one tick in twelve clocks");

    base_six_a: assert property (
        @(posedge clk) disable iff (srst)
        tick6 |=> quiet6 ##1 tick6
    ) else $error("turbo time base is not one tick in six clocks");

    tb_reset_a: assert property (
        @(posedge clk)
        srst |=> timebase_select_bit == `TC_RST_PAIR && turbo == `TC_RST_PAIR
    ) else $error("time-base select not cleared by reset");

    option_force_a: assert property (
        @(posedge clk) disable iff (srst)
        opt_s2 && !cfg[0].ct && count_step[0] |-> tick12
    ) else $error("twelve-clock option did not override turbo");

    status_sticky_a: assert property (
        @(posedge clk) disable iff (srst)
        overflow[0] |=> irq_status[0] && timer_overflow_flag[0] ##1 (irq || !$past(irq_mask[0]))
    ) else $error("overflow lost against a clear or irq wrong");

endmodule : timer_counter

// ---- core/tc_regs.svh ----
// register offsets, field positions, reset values and rates of the timer block
`ifndef TC_REGS_SVH
`define TC_REGS_SVH

`define TC_ADDR_T0_LOW 8'h00
`define TC_ADDR_T0_HIGH 8'h01
`define TC_ADDR_T1_LOW 8'h02
`define TC_ADDR_T1_HIGH 8'h03
`define TC_ADDR_TMODE 8'h04
`define TC_ADDR_TCTRL 8'h05
`define TC_ADDR_CKCTRL 8'h06
`define TC_ADDR_IRQ_STATUS 8'h07
`define TC_ADDR_IRQ_MASK 8'h08

`define TC_TCTRL_RUN0 4
`define TC_TCTRL_FLAG0 5
`define TC_TCTRL_RUN1 6
`define TC_TCTRL_FLAG1 7
`define TC_CK_TB0 3
`define TC_CK_TB1 4

`define TC_RST_BYTE 8'h00
`define TC_RST_PAIR 2'h0
`define TC_CLK_PER_CYCLE 12
`define TC_CLK_PER_TURBO 6
`define TC_MODE13 2'h0
`define TC_PRESCALE_TOP 5'h1f
`define TC_COUNT13_TOP 13'h1fff
`define TC_COUNT13_ZERO 13'h0000

`endif

// ---- core/tc_pkg.sv ----
// types shared by the timer block
package tc_pkg;

    typedef struct packed {
        logic gate;
        logic ct;
        logic mode_field_high;
        logic mode_field_low;
    } mode_cfg_t;

    typedef struct packed {
        mode_cfg_t t1;
        mode_cfg_t t0;
    } tmode_reg_t;

    typedef struct packed {
        logic [7:0] high;
        logic [7:0] low;
    } count_t;

endpackage : tc_pkg

// ---- core/timer_unit.sv ----
// one mode 0 timer: low byte prescaler, high byte counter, overflow pulse
`include "tc_regs.svh"

module timer_unit (
    input wire logic clk,
    input wire logic srst,
    input wire logic count_step,
    input wire logic wr_low,
    input wire logic wr_high,
    input wire logic [7:0] wdata,
    output tc_pkg::count_t cnt,
    output logic overflow
);
    import tc_pkg::*;

    logic step_eff;
    logic at_top;
    logic low_carry;
    logic [7:0] low_byte;
    logic [7:0] high_byte;

    // each byte has its own process, so the struct port is only assembled here
    assign cnt = {high_byte, low_byte};

    // a write to either byte drops the count of that cycle so software sees its own value
    assign step_eff = count_step & ~wr_low & ~wr_high;
    assign low_carry = cnt.low[4:0] == `TC_PRESCALE_TOP;
    assign at_top = {cnt.high, cnt.low[4:0]} == `TC_COUNT13_TOP;

    always_ff @(posedge clk) begin
        if (srst) begin
            low_byte <= `TC_RST_BYTE;
        end else if (wr_low) begin
            low_byte <= wdata;
        end else if (step_eff) begin
            // upper three bits stay out of the count
            low_byte[4:0] <= low_byte[4:0] + 5'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            high_byte <= `TC_RST_BYTE;
        end else if (wr_high) begin
            high_byte <= wdata;
        end else if (step_eff && low_carry) begin
            high_byte <= high_byte + 8'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            overflow <= 1'b0;
        end else begin
            overflow <= step_eff & at_top;
        end
    end

    wrap_to_zero_a: assert property (
        @(posedge clk) disable iff (srst)
        step_eff && at_top |=> {cnt.high, cnt.low[4:0]} == `TC_COUNT13_ZERO && overflow
    ) else $error("mode 0 count did not wrap to zero with overflow");

    prescale_hold_a: assert property (
        @(posedge clk) disable iff (srst)
        step_eff && !low_carry |=> cnt.high == $past(cnt.high)
            && cnt.low[4:0] == 5'($past(cnt.low[4:0]) + 5'h01)
    ) else $error("prescaler step disturbed the high byte");

    upper_bits_a: assert property (
        @(posedge clk) disable iff (srst)
        step_eff |=> cnt.low[7:5] == $past(cnt.low[7:5])
    ) else $error("upper low byte bits changed while counting");

endmodule : timer_unit

// ---- bench/pin_model.sv ----
// board-side model of the count pins and gate pins
module pin_model (
    input wire logic clk,
    output logic count_pin_zero,
    output logic count_pin_one,
    output logic [1:0] gate_pins
);
    timeunit 1ns;
    timeprecision 1ps;

    // count pins rest high as behind a pull-up, gates start closed
    initial begin
        count_pin_zero = 1'b1;
        count_pin_one = 1'b1;
        gate_pins = 2'h0;
    end

    // low level lasts four clocks, high level five before the next pulse: shorter pulses may slip past the sampler
    task automatic pulse(input logic sel, input int n);
        repeat (n) begin
            @(posedge clk);
            if (sel) begin
                count_pin_one <= 1'b0;
            end else begin
                count_pin_zero <= 1'b0;
            end
            repeat (4) @(posedge clk);
            count_pin_zero <= 1'b1;
            count_pin_one <= 1'b1;
            repeat (4) @(posedge clk);
        end
    endtask : pulse

    task automatic set_gate(input logic [1:0] lvl);
        @(posedge clk);
        gate_pins <= lvl;
        repeat (4) @(posedge clk);
    endtask : set_gate
endmodule : pin_model

// ---- bench/timer_counter_tb.sv ----
// self-checking bench for the two mode 0 timer/counters
`include "tc_regs.svh"

module timer_counter_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr_strobe = 1'b0;
    logic rd_strobe = 1'b0;
    logic twelve_clk_option = 1'b0;
    logic [7:0] rdata;
    logic count_pin_zero;
    logic count_pin_one;
    logic [1:0] gate_pins;
    logic irq;
    logic [1:0] timer_irq_req;
    logic [7:0] val;
    int num_errors = 0;
    int check_count = 0;
    int cycles = 0;

    always #10 clk = ~clk;

    timer_counter timer_counter_i (
        .clk(clk), .srst(srst), .addr(addr), .wdata(wdata),
        .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .rdata(rdata),
        .count_pin_zero(count_pin_zero), .count_pin_one(count_pin_one),
        .external_interrupt_pin(gate_pins), .twelve_clk_option(twelve_clk_option),
        .irq(irq), .timer_irq_req(timer_irq_req)
    );

    pin_model pin_model_i (
        .clk(clk), .count_pin_zero(count_pin_zero), .count_pin_one(count_pin_one),
        .gate_pins(gate_pins)
    );

    task automatic wrap_up();
        if (num_errors == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : wrap_up

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_strobe <= 1'b1;
        @(posedge clk);
        wr_strobe <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd_strobe <= 1'b1;
        @(posedge clk);
        rd_strobe <= 1'b0;
        #1;
        d = rdata;
    endtask : rd

    task automatic settle();
        repeat (2) @(posedge clk);
        #1;
    endtask : settle

    // two reads exactly 120 clocks apart, so the divider phase cancels out
    task automatic measure(input logic [7:0] a, output logic [7:0] diff);
        logic [7:0] v0;
        logic [7:0] v1;
        wr(a, 8'h00);
        rd(a, v0);
        repeat (118) @(posedge clk);
        rd(a, v1);
        diff = v1 - v0;
    endtask : measure

    task automatic t_reset();
        rd(`TC_ADDR_TMODE, val);
        check(val, 8'h00);
        rd(`TC_ADDR_CKCTRL, val);
        check(val, 8'h00);
        rd(`TC_ADDR_TCTRL, val);
        check(val, 8'h00);
        rd(8'h20, val);
        check(val, 8'h00);
    endtask : t_reset

    task automatic t_rates();
        wr(`TC_ADDR_TCTRL, 8'h10);
        measure(`TC_ADDR_T0_LOW, val);
        check(val, 8'h0a);
        wr(`TC_ADDR_CKCTRL, 8'h08);
        measure(`TC_ADDR_T0_LOW, val);
        check(val, 8'h14);
        measure(`TC_ADDR_T1_LOW, val);
        check(val, 8'h00);
        twelve_clk_option <= 1'b1;
        measure(`TC_ADDR_T0_LOW, val);
        check(val, 8'h0a);
        twelve_clk_option <= 1'b0;
        wr(`TC_ADDR_CKCTRL, 8'h00);
    endtask : t_rates

    task automatic t_gate();
        wr(`TC_ADDR_TMODE, 8'h08);
        measure(`TC_ADDR_T0_LOW, val);
        check(val, 8'h00);
        pin_model_i.set_gate(2'h1);
        measure(`TC_ADDR_T0_LOW, val);
        check(val, 8'h0a);
        wr(`TC_ADDR_TCTRL, 8'h00);
        measure(`TC_ADDR_T0_LOW, val);
        check(val, 8'h00);
        wr(`TC_ADDR_TMODE, 8'h01);
        wr(`TC_ADDR_TCTRL, 8'h10);
        measure(`TC_ADDR_T0_LOW, val);
        check(val, 8'h00);
        rd(`TC_ADDR_TMODE, val);
        check(val, 8'h01);
    endtask : t_gate

    // timer 1 counts its own pin; timer 0 is on timer source but stopped (RUN0 clear) and must stay at zero
    task automatic t_counter1();
        wr(`TC_ADDR_TMODE, 8'h40);
        wr(`TC_ADDR_TCTRL, 8'h40);
        wr(`TC_ADDR_T1_LOW, 8'h00);
        pin_model_i.pulse(1'b1, 5);
        rd(`TC_ADDR_T1_LOW, val);
        check(val, 8'h05);
        rd(`TC_ADDR_T0_LOW, val);
        check(val, 8'h00);
    endtask : t_counter1

    task automatic load_and_pulse(input logic [7:0] hi);
        wr(`TC_ADDR_T0_HIGH, hi);
        wr(`TC_ADDR_T0_LOW, 8'hff);
        pin_model_i.pulse(1'b0, 1);
    endtask : load_and_pulse

    task automatic t_overflow();
        wr(`TC_ADDR_TMODE, 8'h04);
        wr(`TC_ADDR_TCTRL, 8'h10);
        wr(`TC_ADDR_IRQ_MASK, 8'h01);
        load_and_pulse(8'h00);
        rd(`TC_ADDR_T0_HIGH, val);
        check(val, 8'h01);
        rd(`TC_ADDR_T0_LOW, val);
        check(val, 8'he0);
        check({7'h00, irq}, 8'h00);
        load_and_pulse(8'hff);
        rd(`TC_ADDR_T0_HIGH, val);
        check(val, 8'h00);
        rd(`TC_ADDR_TCTRL, val);
        check(val, 8'h30);
        check({7'h00, irq}, 8'h01);
        check({6'h00, timer_irq_req}, 8'h01);
        wr(`TC_ADDR_IRQ_STATUS, 8'h01);
        settle();
        check({7'h00, irq}, 8'h00);
        check({6'h00, timer_irq_req}, 8'h01);
        wr(`TC_ADDR_TCTRL, 8'h10);
        settle();
        check({6'h00, timer_irq_req}, 8'h00);
        // masked overflow still latches status but raises nothing
        wr(`TC_ADDR_IRQ_MASK, 8'h00);
        load_and_pulse(8'hff);
        rd(`TC_ADDR_IRQ_STATUS, val);
        check(val, 8'h01);
        check({7'h00, irq}, 8'h00);
        check({6'h00, timer_irq_req}, 8'h00);
        wr(`TC_ADDR_IRQ_MASK, 8'h01);
        settle();
        check({7'h00, irq}, 8'h01);
        wr(`TC_ADDR_IRQ_STATUS, 8'h01);
        wr(`TC_ADDR_TCTRL, 8'h00);
    endtask : t_overflow

    // a reset in mid-run must bring both time bases back to divide by twelve
    task automatic t_rereset();
        wr(`TC_ADDR_CKCTRL, 8'h18);
        @(posedge clk);
        srst <= 1'b1;
        @(posedge clk);
        srst <= 1'b0;
        rd(`TC_ADDR_CKCTRL, val);
        check(val, 8'h00);
    endtask : t_rereset

    // run takes about 1200 clocks; ceiling leaves a wide margin
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors++;
            wrap_up();
        end
    end

    initial begin
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        t_reset();
        t_rates();
        t_gate();
        t_counter1();
        t_overflow();
        t_rereset();
        wrap_up();
    end
endmodule : timer_counter_tb
